// ### shared/chan_cfg_pkg.sv
/*
 * Constants for the channel enable latches and link fault block.
 * Assumes one system clock and an 8-bit shared enable bus, four channels.
 */
package chan_cfg_pkg;
    localparam int          BusWidth   = 8;
    localparam int          NumChan    = 4;
    localparam int          IdxWidth   = 3;
    // Pattern-latch reset value: all high keeps every channel in normal mode
    localparam logic [7:0]  TestRstVal = 8'hFF;
    // Power and output latches reset low: everything off
    localparam logic [7:0]  PwrRstVal  = 8'h00;
    localparam logic [7:0]  OeRstVal   = 8'h00;
    // Default bus-bit mapping: tx channel c on bit c, rx channel c on bit c+4
    localparam logic [11:0] TxMapDef   = 12'h688;
    localparam logic [11:0] RxMapDef   = 12'hFAC;
    // Driver mapping, two bits per channel: primary on bit c, secondary on bit c+4
    localparam logic [7:0]  OeMapDef   = 8'hAA;
    localparam int          SyncStages = 2;
endpackage : chan_cfg_pkg

// ### hw/pin_sync.sv
/*
 * Two-stage synchroniser for a vector of asynchronous pins.
 * Assumes pins are quasi-static; the first stage feeds only the second.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int Width = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    input  wire logic [Width-1:0] pinAsync,
    output var  logic [Width-1:0] pinSync
);
    logic [Width-1:0] meta_q;
    logic [Width-1:0] meta_d;
    logic [Width-1:0] sync_d;

    // ============================================================
    // Next values
    always_comb begin
        meta_d = pinAsync;
        sync_d = meta_q;
    end

    // Two flops, reset low
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta_q  <= '0;
            pinSync <= '0;
        end else begin
            meta_q  <= meta_d;
            pinSync <= sync_d;
        end
    end
endmodule // pin_sync
`default_nettype wire

// ### hw/enable_latch.sv
/*
 * One clocked transparent latch fed from the shared enable bus.
 * Follows the bus while its latch enable is high, holds it after the fall.
 * Assumes synchronised inputs and a synchronous clear from the device reset.
 */
`timescale 1ns/1ps
`default_nettype none
module enable_latch
    import chan_cfg_pkg::*;
#(
    parameter logic [BusWidth-1:0] RstVal   = '0,
    parameter bit                  ClrOpen  = 1'b1
) (
    input  wire logic                clk_sys,
    input  wire logic                arst_n,
    input  wire logic                latchEn,
    input  wire logic                devRst,
    input  wire logic [BusWidth-1:0] busIn,
    output var  logic [BusWidth-1:0] held
);
    logic [BusWidth-1:0] held_q;
    logic [BusWidth-1:0] held_d;

    // ============================================================
    // Transparent while enabled, hold otherwise; reset clear
    always_comb begin
        held_d = held_q;
        if (latchEn) begin
            held_d = busIn;
        end
        if (devRst && (ClrOpen || !latchEn)) begin
            held_d = RstVal;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            held_q <= RstVal;
        end else begin
            held_q <= held_d;
        end
    end

    assign held = held_q;
endmodule // enable_latch
`default_nettype wire

// ### hw/channel_enable_latches_fault.sv
/*
 * Per-channel configuration latches and link fault outputs.
 * Three latches share one 8-bit enable bus: test pattern, receive power,
 * and serial output enable. Each channel has an active-low fault output.
 * Assumes all pin inputs are asynchronous and fault conditions arrive as
 * asynchronous levels from the analog front end.
 */
`timescale 1ns/1ps
`default_nettype none

module channel_enable_latches_fault
    import chan_cfg_pkg::*;
#(
    parameter logic [NumChan*IdxWidth-1:0] TxMap = TxMapDef,
    parameter logic [NumChan*IdxWidth-1:0] RxMap = RxMapDef,
    parameter logic [2*NumChan-1:0]        OeMap = OeMapDef
) (
    input  wire logic                          clk_sys,
    input  wire logic                          arst_n,
    input  wire logic                          device_reset_n,
    input  wire logic                          test_latch_enable,
    input  wire logic                          rx_power_latch_enable,
    input  wire logic                          output_enable_latch_enable,
    input  wire logic [chan_cfg_pkg::BusWidth-1:0] shared_enable_bus,
    input  wire logic [chan_cfg_pkg::NumChan-1:0]  freqFault,
    input  wire logic [chan_cfg_pkg::NumChan-1:0]  amplFault,
    input  wire logic [chan_cfg_pkg::NumChan-1:0]  densFault,
    output var  logic [chan_cfg_pkg::NumChan-1:0]  txPatternGen,
    output var  logic [chan_cfg_pkg::NumChan-1:0]  rxPatternCheck,
    output var  logic [chan_cfg_pkg::NumChan-1:0]  rxPowerOn,
    output var  logic [chan_cfg_pkg::NumChan-1:0]  primaryDriveOn,
    output var  logic [chan_cfg_pkg::NumChan-1:0]  secondaryDriveOn,
    output var  logic [chan_cfg_pkg::NumChan-1:0]  link_fault_n
);
    import chan_cfg_pkg::*;

    // ============================================================
    // Elaboration checks
    if (BusWidth != 2 * NumChan) begin : g_bad_width
        $error("enable bus must be two bits per channel");
    end

    // ============================================================
    // Input synchronisers
    localparam int PinW = BusWidth + 4 + 3 * NumChan;

    logic [PinW-1:0]     pinSync;
    logic [BusWidth-1:0] busS;
    logic                testLeS;
    logic                rxLeS;
    logic                oeLeS;
    logic                devRstS;
    logic [NumChan-1:0]  freqS;
    logic [NumChan-1:0]  amplS;
    logic [NumChan-1:0]  densS;

    pin_sync #(
        .Width (PinW)
    ) u_sync (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .pinAsync ({shared_enable_bus, test_latch_enable, rx_power_latch_enable,
                    output_enable_latch_enable, ~device_reset_n,
                    freqFault, amplFault, densFault}),
        .pinSync  (pinSync)
    );

    // Unpack synchronised pins
    assign {busS, testLeS, rxLeS, oeLeS, devRstS, freqS, amplS, densS} = pinSync;

    // ============================================================
    // The three latches on the shared bus
    logic [BusWidth-1:0] testHeld;
    logic [BusWidth-1:0] pwrHeld;
    logic [BusWidth-1:0] oeHeld;

    // Pattern latch: clears only while closed
    enable_latch #(
        .RstVal  (TestRstVal),
        .ClrOpen (1'b0)
    ) u_test_latch (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .latchEn (testLeS),
        .devRst  (devRstS),
        .busIn   (busS),
        .held    (testHeld)
    );

    // Receive power latch: clears whenever reset is low
    enable_latch #(
        .RstVal  (PwrRstVal),
        .ClrOpen (1'b1)
    ) u_pwr_latch (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .latchEn (rxLeS),
        .devRst  (devRstS),
        .busIn   (busS),
        .held    (pwrHeld)
    );

    // Output-enable latch: clears whenever reset is sampled low
    enable_latch #(
        .RstVal  (OeRstVal),
        .ClrOpen (1'b1)
    ) u_oe_latch (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .latchEn (oeLeS),
        .devRst  (devRstS),
        .busIn   (busS),
        .held    (oeHeld)
    );

    // ============================================================
    // Per-channel mapping and fault combining
    logic [NumChan-1:0] txGen_d;
    logic [NumChan-1:0] rxChk_d;
    logic [NumChan-1:0] rxPwr_d;
    logic [NumChan-1:0] priDrv_d;
    logic [NumChan-1:0] secDrv_d;
    logic [NumChan-1:0] fault_d;
    logic [NumChan-1:0] txGen_q;
    logic [NumChan-1:0] rxChk_q;
    logic [NumChan-1:0] rxPwr_q;
    logic [NumChan-1:0] priDrv_q;
    logic [NumChan-1:0] secDrv_q;
    logic [NumChan-1:0] faultN_q;

    for (genvar c = 0; c < NumChan; c++) begin : g_chan
        localparam logic [IdxWidth-1:0] TxIdx = TxMap[c*IdxWidth +: IdxWidth];
        localparam logic [IdxWidth-1:0] RxIdx = RxMap[c*IdxWidth +: IdxWidth];
        // Low bit selects pattern mode, high bit normal data
        assign txGen_d[c]  = ~testHeld[TxIdx];
        assign rxChk_d[c]  = ~testHeld[RxIdx];
        // High bit powers the receive channel, low powers it down
        assign rxPwr_d[c]  = pwrHeld[RxIdx];
        // Each channel owns two drivers
        assign priDrv_d[c] = oeHeld[OeMap[2*c]   ? c + NumChan : c];
        assign secDrv_d[c] = oeHeld[OeMap[2*c+1] ? c + NumChan : c];
        // OR of four conditions
        assign fault_d[c]  = freqS[c] | amplS[c]
                           | densS[c] | ~rxPwr_d[c];
    end

    // ============================================================
    // Output registers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            txGen_q  <= '0;
            rxChk_q  <= '0;
            rxPwr_q  <= '0;
            priDrv_q <= '0;
            secDrv_q <= '0;
            faultN_q <= '0;
        end else begin
            txGen_q  <= txGen_d;
            rxChk_q  <= rxChk_d;
            rxPwr_q  <= rxPwr_d;
            priDrv_q <= priDrv_d;
            secDrv_q <= secDrv_d;
            faultN_q <= ~fault_d;
        end
    end

    // Straight from flops
    assign txPatternGen     = txGen_q;
    assign rxPatternCheck   = rxChk_q;
    assign rxPowerOn        = rxPwr_q;
    assign primaryDriveOn   = priDrv_q;
    assign secondaryDriveOn = secDrv_q;
    assign link_fault_n     = faultN_q;
endmodule // channel_enable_latches_fault
`default_nettype wire

// ### dv/channel_enable_latches_fault_sva.sv
/* Checker for the channel enable latches and link fault outputs.
   Assumes default bus mapping, four edges from bus and enable pins to outputs, three from fault pins. */
`timescale 1ns/1ps
`default_nettype none
module channel_enable_latches_fault_sva
    import chan_cfg_pkg::*;
(
    input wire logic                               clk_sys,
    input wire logic                               arst_n,
    input wire logic                               device_reset_n,
    input wire logic                               test_latch_enable,
    input wire logic                               rx_power_latch_enable,
    input wire logic                               output_enable_latch_enable,
    input wire logic [chan_cfg_pkg::BusWidth-1:0] shared_enable_bus,
    input wire logic [chan_cfg_pkg::NumChan-1:0]  freqFault,
    input wire logic [chan_cfg_pkg::NumChan-1:0]  amplFault,
    input wire logic [chan_cfg_pkg::NumChan-1:0]  densFault,
    input wire logic [chan_cfg_pkg::NumChan-1:0]  txPatternGen,
    input wire logic [chan_cfg_pkg::NumChan-1:0]  rxPatternCheck,
    input wire logic [chan_cfg_pkg::NumChan-1:0]  rxPowerOn,
    input wire logic [chan_cfg_pkg::NumChan-1:0]  primaryDriveOn,
    input wire logic [chan_cfg_pkg::NumChan-1:0]  secondaryDriveOn,
    input wire logic [chan_cfg_pkg::NumChan-1:0]  link_fault_n
);
    logic [2:0] upCnt_q;
    logic [2:0] upCnt_d;
    logic       up;
    // Edges since reset release; checks wait until the pipeline is full
    always_comb begin
        upCnt_d = (upCnt_q == 3'h7) ? upCnt_q : upCnt_q + 3'h1;
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            upCnt_q <= 3'h0;
        end else begin
            upCnt_q <= upCnt_d;
        end
    end
    assign up = (upCnt_q == 3'h7);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    // ==========================================================
    // Latch behaviour four edges after the pins; link fault three edges after the fault pins
    AST_TEST_TX: assert property (up && $past(test_latch_enable, 4)
        |-> txPatternGen == ~$past(shared_enable_bus[3:0], 4)) else $error("tx pattern");
    AST_TEST_RX: assert property (up && $past(test_latch_enable, 4)
        |-> rxPatternCheck == ~$past(shared_enable_bus[7:4], 4)) else $error("rx pattern");
    AST_TEST_HOLD: assert property (up && !$past(test_latch_enable, 4)
        && $past(device_reset_n, 4) |-> $stable({txPatternGen, rxPatternCheck}))
        else $error("pattern not held");
    AST_TEST_CLEAR: assert property (up && !$past(test_latch_enable, 4)
        && !$past(device_reset_n, 4) |-> {txPatternGen, rxPatternCheck} == 8'h00)
        else $error("pattern not cleared");
    AST_PWR_FOLLOW: assert property (up && $past(rx_power_latch_enable, 4)
        && $past(device_reset_n, 4) |-> rxPowerOn == $past(shared_enable_bus[7:4], 4))
        else $error("power follow");
    AST_PWR_HOLD: assert property (up && !$past(rx_power_latch_enable, 4)
        && $past(device_reset_n, 4) |-> $stable(rxPowerOn)) else $error("power not held");
    AST_PWR_CLEAR: assert property (up && !$past(device_reset_n, 4)
        |-> rxPowerOn == 4'h0) else $error("power not cleared");
    AST_OE_FOLLOW: assert property (up && $past(output_enable_latch_enable, 4)
        && $past(device_reset_n, 4) |-> {secondaryDriveOn, primaryDriveOn}
        == $past(shared_enable_bus, 4)) else $error("driver follow");
    AST_OE_CLEAR: assert property (up && !$past(device_reset_n, 4)
        |-> {secondaryDriveOn, primaryDriveOn} == 8'h00) else $error("driver not cleared");
    AST_FAULT: assert property (up |-> link_fault_n == (rxPowerOn
        & ~$past(freqFault | amplFault | densFault, 3))) else $error("link fault");
endmodule // channel_enable_latches_fault_sva
bind channel_enable_latches_fault channel_enable_latches_fault_sva i_sva (.clk_sys, .arst_n,
    .device_reset_n, .test_latch_enable, .rx_power_latch_enable, .output_enable_latch_enable,
    .shared_enable_bus, .freqFault, .amplFault, .densFault, .txPatternGen, .rxPatternCheck,
    .rxPowerOn, .primaryDriveOn, .secondaryDriveOn, .link_fault_n);
`default_nettype wire

// ### dv/host_pins_model.sv
/* Host model driving the static pins: enables, shared bus, device reset, faults.
   Assumes clk_sys from the bench; pins change 1 ns after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module host_pins_model (
    input  wire logic        clk_sys,
    output var  logic        devRstN,
    output var  logic [2:0]  latchEn,
    output var  logic [7:0]  busOut,
    output var  logic [11:0] faults
);
    // Idle pins: bus pulled high, all latches closed
    initial begin
        devRstN = 1'b1;
        latchEn = 3'b000;
        busOut  = 8'hFF;
        faults  = 12'h000;
    end
    // One pin state, then held six cycles so bus settles around each enable fall
    task automatic drive(input logic rst, input logic [2:0] en, input logic [7:0] bus,
                         input logic [11:0] flt);
        @(posedge clk_sys);
        #1;
        devRstN = rst;
        latchEn = en;
        busOut  = bus;
        faults  = flt;
        repeat (6) @(posedge clk_sys);
        #1;
    endtask
endmodule // host_pins_model
`default_nettype wire

// ### dv/channel_enable_latches_fault_bench.sv
/* Bench for the channel enable latches: pin sequences with expected outputs.
   Assumes default bus mapping; tx c on bit c, rx c on bit c+4. */
`timescale 1ns/1ps
`default_nettype none
module channel_enable_latches_fault_bench;
    logic        clk_sys = 1'b0;
    logic        arst_n  = 1'b0;
    wire logic        devRstN;
    wire logic [2:0]  en;
    wire logic [7:0]  bus;
    wire logic [11:0] flt;
    logic [3:0]  tx, rx, pw, pri, sec, lf;
    int          miscompares = 0;
    int          compares    = 0;
    always #2 clk_sys = ~clk_sys;
    host_pins_model i_host_pins_model (.clk_sys(clk_sys), .devRstN(devRstN), .latchEn(en),
        .busOut(bus), .faults(flt));
    channel_enable_latches_fault i_channel_enable_latches_fault (.clk_sys(clk_sys),
        .arst_n(arst_n), .device_reset_n(devRstN), .test_latch_enable(en[0]),
        .rx_power_latch_enable(en[1]), .output_enable_latch_enable(en[2]),
        .shared_enable_bus(bus), .freqFault(flt[3:0]), .amplFault(flt[7:4]),
        .densFault(flt[11:8]), .txPatternGen(tx), .rxPatternCheck(rx), .rxPowerOn(pw),
        .primaryDriveOn(pri), .secondaryDriveOn(sec), .link_fault_n(lf));
    // ==========================================================
    // Compare, verdict and the pin sequence
    task automatic check(input string name, input logic [3:0] exp, input logic [3:0] seen);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic all(input logic [3:0] t, r, p, a, b, f);
        check("txPatternGen", t, tx);
        check("rxPatternCheck", r, rx);
        check("rxPowerOn", p, pw);
        check("primaryDriveOn", a, pri);
        check("secondaryDriveOn", b, sec);
        check("link_fault_n", f, lf);
    endtask
    task automatic results();
        if (miscompares == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Watchdog against a hung sequence
    initial begin
        #4000;
        miscompares++;
        results();
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        #1 arst_n = 1'b1;
        i_host_pins_model.drive(1'b1, 3'b000, 8'hFF, 12'h000);
        all(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
        i_host_pins_model.drive(1'b1, 3'b001, 8'h0F, 12'h000);
        all(4'h0, 4'hF, 4'h0, 4'h0, 4'h0, 4'h0);
        i_host_pins_model.drive(1'b1, 3'b001, 8'h5A, 12'h000);
        all(4'h5, 4'hA, 4'h0, 4'h0, 4'h0, 4'h0);
        i_host_pins_model.drive(1'b1, 3'b000, 8'h5A, 12'h000);
        i_host_pins_model.drive(1'b1, 3'b000, 8'h00, 12'h000);
        all(4'h5, 4'hA, 4'h0, 4'h0, 4'h0, 4'h0);
        i_host_pins_model.drive(1'b1, 3'b010, 8'hA5, 12'h000);
        i_host_pins_model.drive(1'b1, 3'b000, 8'hA5, 12'h000);
        i_host_pins_model.drive(1'b1, 3'b000, 8'h0F, 12'h000);
        all(4'h5, 4'hA, 4'hA, 4'h0, 4'h0, 4'hA);
        i_host_pins_model.drive(1'b1, 3'b100, 8'h3C, 12'h000);
        i_host_pins_model.drive(1'b1, 3'b000, 8'h3C, 12'h000);
        i_host_pins_model.drive(1'b1, 3'b000, 8'hFF, 12'h000);
        all(4'h5, 4'hA, 4'hA, 4'hC, 4'h3, 4'hA);
        for (int i = 0; i < 3; i++) begin
            i_host_pins_model.drive(1'b1, 3'b000, 8'hFF, 12'h002 << (4 * i));
            check("link_fault_n", 4'h8, lf);
        end
        i_host_pins_model.drive(1'b0, 3'b000, 8'hFF, 12'h000);
        all(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
        i_host_pins_model.drive(1'b0, 3'b111, 8'h00, 12'h000);
        all(4'hF, 4'hF, 4'h0, 4'h0, 4'h0, 4'h0);
        results();
    end
endmodule // channel_enable_latches_fault_bench
`default_nettype wire
